// ==== rtl/atsc_err_corr.sv ====
// Digital error correction combining pipeline stage digits into one sample
`timescale 1ns/100ps
`include "atsc_defines.svh"
module atsc_err_corr #(
    parameter int NST = 12
) (
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic [2*NST-1:0]  stage_digits,
    input  wire logic              final_bit,
    output logic      [12:0]       sample_ff
);

    // Overlapping stage digits, first stage most significant
    function automatic logic [12:0] correct(input logic [2*NST-1:0] d, input logic f);
        logic [14:0] acc;
        logic [1:0]  dig;
        acc = 15'(f);
        for (int i = 0; i < NST; i++) begin
            dig = d[2*i+:2];
            if (dig == 2'h3) begin
                dig = 2'h2;
            end
            acc = acc + (15'(dig) << (NST - 1 - i));
        end
        if (acc > `ATSC_SAMPLE_MAX) begin
            acc = `ATSC_SAMPLE_MAX;
        end
        return acc[12:0];
    endfunction

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sample_ff <= 13'h0000;
        end else begin
            sample_ff <= correct(stage_digits, final_bit);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    property p_ecc_zero;
        (stage_digits == '0) && !final_bit |=> sample_ff == 13'h0000;
    endproperty
    a_ecc_zero: assert property (p_ecc_zero) else $error("lowest input not code 0");

    property p_ecc_full;
        (stage_digits == {NST{2'h2}}) && final_bit |=> sample_ff == 13'h1fff;
    endproperty
    a_ecc_full: assert property (p_ecc_full) else $error("highest input not code 8191");

    property p_ecc_step;
        (stage_digits == $past(stage_digits)) && $rose(final_bit)
            && (stage_digits != {NST{2'h2}})
            |=> sample_ff == $past(sample_ff) + 13'h0001;
    endproperty
    a_ecc_step: assert property (p_ecc_step) else $error("final stage not weighted 1");

endmodule // atsc_err_corr

// ==== rtl/atsc_top.sv ====
// Converter trim, performance, wake-up control and serial output framing
// Function
// - Six-bit trim at 0x55, reset mid code
// - Trim offset from mid code 100000
// - Higher trim code never lowers range
// - Two-bit clock range setting held
// - Wake counts 992, 640, 420, 260 cycles
// - Range affects only wake-up delays
// - Performance level at 0x50, reset nominal
// - Codes 100-111 cut power; 001-011 forbidden
// - Buffer strength field bits 5:4, default 01
// - Sample serialised per channel, 12/14 bits
// - Half-rate bit clock and frame clock out
// - All channels sampled on one clock
// - Code 0 lowest, 8191 highest input
// - Stage digits combined by error correction
// - 12-bit drops LSB; 14-bit appends zero
`timescale 1ns/100ps
`include "atsc_defines.svh"
module atsc_top #(
    parameter int NCH = 8,
    parameter int NST = 12
) (
    input  wire logic                   mclk,
    input  wire logic                   resetn,
    input  wire logic                   ctl_cs_n,
    input  wire logic                   ctl_sclk,
    input  wire logic                   ctl_sdata,
    output logic                        ctl_sdout_ff,
    input  wire logic                   pd_req,
    input  wire logic                   sleep_req,
    input  wire logic [NCH*NST*2-1:0]   stage_digits,
    input  wire logic [NCH-1:0]         final_bits,
    output logic      [NCH-1:0]         serial_data_ff,
    output logic                        frame_clock_ff,
    output logic                        bit_clock_half_ff,
    output logic                        wake_ready_ff,
    output atsc_pkg::atsc_perf_t        perf_level_ff,
    output logic      [1:0]             common_mode_buffer_strength_ff,
    output logic      [5:0]             full_scale_trim_ff,
    output logic signed [6:0]           trim_offset_ff
);

    // Control port state
    logic                        sclk_q_ff;
    logic                        cs_q_ff;
    logic [4:0]                  bit_cnt_ff;
    logic [23:0]                 ctl_shift_ff;
    logic [15:0]                 rd_shift_ff;
    logic                        sclk_rise;
    logic                        cs_rise;
    logic                        wr_en;
    logic [7:0]                  wr_addr;
    logic [15:0]                 wr_data;
    logic [7:0]                  rd_addr;
    logic [15:0]                 rd_word;

    // Configuration registers
    atsc_pkg::atsc_perf_t        perf_raw_ff;
    atsc_pkg::atsc_clk_range_t   clk_range_ff;
    logic                        num_bits_ff;
    logic                        wake_busy;

    // Serialiser state
    logic [3:0]                  frame_cnt_ff;
    logic                        nb_frame_ff;
    logic                        frame_end;
    logic [3:0]                  cur_len;
    logic [3:0]                  nxt_frame_cnt;
    logic [12:0]                 sample   [NCH];
    logic [13:0]                 word_ff  [NCH];
    logic [3:0]                  gap_ff;

    function automatic logic [3:0] frame_len(input logic nb);
        return nb ? `ATSC_WORD_LEN_14 : `ATSC_WORD_LEN_12;
    endfunction

    function automatic logic [13:0] fmt_word(input logic [12:0] s, input logic nb);
        return nb ? {s, 1'b0} : {2'b00, s[12:1]};
    endfunction

    function automatic logic perf_legal(input atsc_pkg::atsc_perf_t p);
        return p[2] || (p == 3'h0);
    endfunction

    function automatic logic [15:0] reg_read(input logic [7:0] a);
        case (a)
            `ATSC_ADDR_PERF:
                reg_read = {10'h000, common_mode_buffer_strength_ff, 1'b0, perf_raw_ff};
            `ATSC_ADDR_NUM_BITS:
                reg_read = {14'h0000, num_bits_ff, 1'b0};
            `ATSC_ADDR_TRIM:
                reg_read = {10'h000, full_scale_trim_ff};
            `ATSC_ADDR_CLK_RANGE:
                reg_read = {14'h0000, clk_range_ff};
            `ATSC_ADDR_STATUS:
                reg_read = {14'h0000, wake_busy, wake_ready_ff};
            default:
                reg_read = 16'h0000;
        endcase
    endfunction

    // Serial control port framing: 8 address bits then 16 data bits, MSB first
    assign sclk_rise = ctl_sclk & ~sclk_q_ff & ~ctl_cs_n;
    assign cs_rise   = ctl_cs_n & ~cs_q_ff;
    assign wr_en     = cs_rise && (bit_cnt_ff == `ATSC_CTL_FRAME_BITS);
    assign wr_addr   = ctl_shift_ff[23:16];
    assign wr_data   = ctl_shift_ff[15:0];
    assign rd_addr   = {ctl_shift_ff[6:0], ctl_sdata};

    always_comb begin
        rd_word = reg_read(rd_addr);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sclk_q_ff <= 1'b0;
            cs_q_ff   <= 1'b1;
        end else begin
            sclk_q_ff <= ctl_sclk;
            cs_q_ff   <= ctl_cs_n;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bit_cnt_ff   <= 5'h00;
            ctl_shift_ff <= 24'h000000;
        end else if (ctl_cs_n) begin
            bit_cnt_ff <= 5'h00;
        end else if (sclk_rise) begin
            ctl_shift_ff <= {ctl_shift_ff[22:0], ctl_sdata};
            if (bit_cnt_ff != 5'h1f) begin
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
            end
        end
    end

    // Read data follows the address byte
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rd_shift_ff  <= 16'h0000;
            ctl_sdout_ff <= 1'b0;
        end else if (ctl_cs_n) begin
            ctl_sdout_ff <= 1'b0;
        end else if (sclk_rise && (bit_cnt_ff == `ATSC_CTL_ADDR_LAST)) begin
            ctl_sdout_ff <= rd_word[15];
            rd_shift_ff  <= {rd_word[14:0], 1'b0};
        end else if (sclk_rise) begin
            ctl_sdout_ff <= rd_shift_ff[15];
            rd_shift_ff  <= {rd_shift_ff[14:0], 1'b0};
        end
    end

    // Register writes
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            full_scale_trim_ff <= `ATSC_TRIM_RST;
        end else if (wr_en && (wr_addr == `ATSC_ADDR_TRIM)) begin
            full_scale_trim_ff <= wr_data[`ATSC_TRIM_MSB:`ATSC_TRIM_LSB];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            perf_raw_ff                    <= `ATSC_PERF_RST;
            common_mode_buffer_strength_ff <= `ATSC_VCM_RST;
        end else if (wr_en && (wr_addr == `ATSC_ADDR_PERF)) begin
            perf_raw_ff                    <= wr_data[`ATSC_PERF_MSB:`ATSC_PERF_LSB];
            common_mode_buffer_strength_ff <= wr_data[`ATSC_VCM_MSB:`ATSC_VCM_LSB];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            clk_range_ff <= `ATSC_CLKR_RST;
        end else if (wr_en && (wr_addr == `ATSC_ADDR_CLK_RANGE)) begin
            clk_range_ff <= wr_data[`ATSC_CLKR_MSB:`ATSC_CLKR_LSB];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            num_bits_ff <= `ATSC_NUM_BITS_RST;
        end else if (wr_en && (wr_addr == `ATSC_ADDR_NUM_BITS)) begin
            num_bits_ff <= wr_data[`ATSC_NUM_BITS_POS];
        end
    end

    // Derived analog settings
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            perf_level_ff  <= `ATSC_PERF_RST;
            trim_offset_ff <= 7'sh00;
        end else begin
            perf_level_ff  <= perf_legal(perf_raw_ff) ? perf_raw_ff : 3'h0;
            trim_offset_ff <= $signed({1'b0, full_scale_trim_ff} - `ATSC_TRIM_MID);
        end
    end

    // Wake-up timing
    atsc_wake_ctr u_wake (
        .mclk      (mclk),
        .resetn    (resetn),
        .pd_req    (pd_req),
        .sleep_req (sleep_req),
        .clk_range (clk_range_ff),
        .ready_ff  (wake_ready_ff),
        .busy_ff   (wake_busy)
    );

    // Frame timing
    assign cur_len       = frame_len(nb_frame_ff);
    assign frame_end     = (frame_cnt_ff == cur_len - 4'h1);
    assign nxt_frame_cnt = frame_end ? 4'h0 : frame_cnt_ff + 4'h1;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            frame_cnt_ff      <= 4'h0;
            nb_frame_ff       <= `ATSC_NUM_BITS_RST;
            frame_clock_ff    <= 1'b1;
            bit_clock_half_ff <= 1'b0;
        end else begin
            frame_cnt_ff      <= nxt_frame_cnt;
            bit_clock_half_ff <= ~bit_clock_half_ff;
            if (frame_end) begin
                nb_frame_ff    <= num_bits_ff;
                frame_clock_ff <= 1'b1;
            end else begin
                frame_clock_ff <= (nxt_frame_cnt < (cur_len >> 1));
            end
        end
    end

    // Per-channel correction and serialisation on the shared clock
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        atsc_err_corr #(
            .NST (NST)
        ) u_ecc (
            .mclk         (mclk),
            .resetn       (resetn),
            .stage_digits (stage_digits[c*NST*2 +: NST*2]),
            .final_bit    (final_bits[c]),
            .sample_ff    (sample[c])
        );

        logic [13:0] fmt_w;
        assign fmt_w = fmt_word(sample[c], num_bits_ff);

        always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
                word_ff[c]        <= 14'h0000;
                serial_data_ff[c] <= 1'b0;
            end else if (frame_end) begin
                word_ff[c]        <= wake_ready_ff ? fmt_w : 14'h0000;
                serial_data_ff[c] <= wake_ready_ff & fmt_w[0];
            end else begin
                word_ff[c]        <= {1'b0, word_ff[c][13:1]};
                serial_data_ff[c] <= word_ff[c][1];
            end
        end
    end

    // Assertion helper: cycles since the last frame end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            gap_ff <= 4'h0;
        end else begin
            gap_ff <= frame_end ? 4'h0 : gap_ff + 4'h1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    property p_trim_write;
        wr_en && (wr_addr == 8'h55) |=> full_scale_trim_ff == $past(wr_data[5:0]);
    endproperty
    a_trim_write: assert property (p_trim_write) else $error("trim write lost");

    property p_trim_offset;
        ##1 trim_offset_ff == $signed(7'($past(full_scale_trim_ff)) - 7'h20);
    endproperty
    a_trim_offset: assert property (p_trim_offset) else $error("trim offset wrong");

    property p_trim_mono;
        (full_scale_trim_ff > $past(full_scale_trim_ff)) |=> trim_offset_ff > $past(trim_offset_ff);
    endproperty
    a_trim_mono: assert property (p_trim_mono) else $error("trim not monotonic");

    property p_perf_legal;
        perf_level_ff[2] || (perf_level_ff == 3'h0);
    endproperty
    a_perf_legal: assert property (p_perf_legal) else $error("forbidden level applied");

    property p_perf_follow;
        wr_en && (wr_addr == 8'h50) && wr_data[2] |-> ##2 perf_level_ff == $past(wr_data[2:0], 2);
    endproperty
    a_perf_follow: assert property (p_perf_follow) else $error("level not applied");

    property p_vcm_write;
        wr_en && (wr_addr == 8'h50) |=> common_mode_buffer_strength_ff == $past(wr_data[5:4]);
    endproperty
    a_vcm_write: assert property (p_vcm_write) else $error("buffer strength lost");

    property p_fmt12;
        frame_end && !num_bits_ff && wake_ready_ff
            |=> word_ff[0] == {2'b00, $past(sample[0][12:1])};
    endproperty
    a_fmt12: assert property (p_fmt12) else $error("12-bit word wrong");

    property p_fmt14;
        frame_end && num_bits_ff && wake_ready_ff
            |=> !serial_data_ff[0] ##1 serial_data_ff[0] == $past(sample[0][0], 2);
    endproperty
    a_fmt14: assert property (p_fmt14) else $error("14-bit LSB not zero");

    property p_frame12;
        frame_end && !nb_frame_ff |-> gap_ff == 4'hb;
    endproperty
    a_frame12: assert property (p_frame12) else $error("12-bit frame length");

    property p_bitclk;
        bit_clock_half_ff |=> !bit_clock_half_ff ##1 bit_clock_half_ff;
    endproperty
    a_bitclk: assert property (p_bitclk) else $error("bit clock not half rate");

    property p_cv_trim;
        wr_en && (wr_addr == 8'h55);
    endproperty
    c_trim: cover property (p_cv_trim);

    property p_cv_14bit;
        frame_end && nb_frame_ff && wake_ready_ff;
    endproperty
    c_14bit: cover property (p_cv_14bit);

    property p_cv_wake;
        $rose(wake_ready_ff);
    endproperty
    c_wake: cover property (p_cv_wake);

    property p_cv_illegal;
        wr_en && (wr_addr == 8'h50) && (wr_data[2:0] == 3'h2);
    endproperty
    c_illegal: cover property (p_cv_illegal);

endmodule // atsc_top

// ==== rtl/atsc_wake_ctr.sv ====
// Wake-up delay counter for leaving power down or deep sleep
`timescale 1ns/100ps
`include "atsc_defines.svh"
module atsc_wake_ctr (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        pd_req,
    input  wire logic        sleep_req,
    input  wire logic [1:0]  clk_range,
    output logic             ready_ff,
    output logic             busy_ff
);

    atsc_pkg::atsc_wake_e state_ff;
    logic [9:0]           cnt_ff;
    logic                 intr_ff;
    logic                 req;

    assign req = pd_req | sleep_req;

    function automatic logic [9:0] wake_count(input logic [1:0] r);
        case (r)
            2'h0:    return `ATSC_WAKE_CNT_00;
            2'h1:    return `ATSC_WAKE_CNT_01;
            2'h2:    return `ATSC_WAKE_CNT_10;
            default: return `ATSC_WAKE_CNT_11;
        endcase
    endfunction

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= atsc_pkg::ATSC_WAKE;
            cnt_ff   <= `ATSC_WAKE_CNT_00;
            ready_ff <= 1'b0;
            busy_ff  <= 1'b1;
        end else begin
            case (state_ff)
                atsc_pkg::ATSC_RUN: begin
                    if (req) begin
                        state_ff <= atsc_pkg::ATSC_DOWN;
                        ready_ff <= 1'b0;
                    end
                end
                atsc_pkg::ATSC_DOWN: begin
                    if (!req) begin
                        state_ff <= atsc_pkg::ATSC_WAKE;
                        cnt_ff   <= wake_count(clk_range);
                        busy_ff  <= 1'b1;
                    end
                end
                atsc_pkg::ATSC_WAKE: begin
                    if (req) begin
                        state_ff <= atsc_pkg::ATSC_DOWN;
                        busy_ff  <= 1'b0;
                    end else if (cnt_ff == 10'h001) begin
                        state_ff <= atsc_pkg::ATSC_RUN;
                        ready_ff <= 1'b1;
                        busy_ff  <= 1'b0;
                    end else begin
                        cnt_ff <= cnt_ff - 10'h001;
                    end
                end
                default: begin
                    state_ff <= atsc_pkg::ATSC_DOWN;
                    ready_ff <= 1'b0;
                    busy_ff  <= 1'b0;
                end
            endcase
        end
    end

    // Assertion helper: wake interrupted by a new request
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            intr_ff <= 1'b0;
        end else if (state_ff == atsc_pkg::ATSC_RUN) begin
            intr_ff <= 1'b0;
        end else if ((state_ff == atsc_pkg::ATSC_WAKE) && req) begin
            intr_ff <= 1'b1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    property p_wake_260;
        (state_ff == atsc_pkg::ATSC_DOWN) && !req && (clk_range == 2'h3)
            |-> ##260 !ready_ff ##1 (ready_ff || intr_ff);
    endproperty
    a_wake_260: assert property (p_wake_260) else $error("range 11 wake not 260 cycles");

    property p_wake_992_load;
        (state_ff == atsc_pkg::ATSC_DOWN) && !req && (clk_range == 2'h0)
            |=> cnt_ff == 10'h3e0;
    endproperty
    a_wake_992_load: assert property (p_wake_992_load) else $error("range 00 not 992");

    property p_wake_hold;
        (state_ff == atsc_pkg::ATSC_WAKE) && !req && (cnt_ff != 10'h001)
            |=> cnt_ff == $past(cnt_ff) - 10'h001;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("running count disturbed");

    property p_run_stays;
        (state_ff == atsc_pkg::ATSC_RUN) && !req |=> ready_ff;
    endproperty
    a_run_stays: assert property (p_run_stays) else $error("ready lost without request");

endmodule // atsc_wake_ctr

// ==== shared/atsc_defines.svh ====
// Register offsets, field positions, reset values and counts for the converter control
`ifndef ATSC_DEFINES_SVH
`define ATSC_DEFINES_SVH

`define ATSC_ADDR_PERF       8'h50
`define ATSC_ADDR_NUM_BITS   8'h53
`define ATSC_ADDR_TRIM       8'h55
`define ATSC_ADDR_CLK_RANGE  8'h56
`define ATSC_ADDR_STATUS     8'h57

`define ATSC_PERF_MSB        2
`define ATSC_PERF_LSB        0
`define ATSC_VCM_MSB         5
`define ATSC_VCM_LSB         4
`define ATSC_TRIM_MSB        5
`define ATSC_TRIM_LSB        0
`define ATSC_NUM_BITS_POS    1
`define ATSC_CLKR_MSB        1
`define ATSC_CLKR_LSB        0

`define ATSC_PERF_RST        3'h0
`define ATSC_VCM_RST         2'h1
`define ATSC_TRIM_RST        6'h20
`define ATSC_NUM_BITS_RST    1'h0
`define ATSC_CLKR_RST        2'h0
`define ATSC_TRIM_MID        7'h20

`define ATSC_WAKE_CNT_00     10'h3e0
`define ATSC_WAKE_CNT_01     10'h280
`define ATSC_WAKE_CNT_10     10'h1a4
`define ATSC_WAKE_CNT_11     10'h104

`define ATSC_CTL_FRAME_BITS  5'h18
`define ATSC_CTL_ADDR_LAST   5'h07
`define ATSC_WORD_LEN_12     4'hc
`define ATSC_WORD_LEN_14     4'he
`define ATSC_SAMPLE_MAX      15'h1fff

`endif

// ==== shared/atsc_pkg.sv ====
// Types shared by the converter control blocks
package atsc_pkg;
    typedef enum logic [1:0] {
        ATSC_RUN  = 2'b00,
        ATSC_DOWN = 2'b01,
        ATSC_WAKE = 2'b11
    } atsc_wake_e;

    typedef logic [2:0] atsc_perf_t;
    typedef logic [1:0] atsc_clk_range_t;
endpackage

// ==== tb/atsc_rx_model.sv ====
// Receiver model capturing channel 0 serial words
`timescale 1ns/100ps
module atsc_rx_model (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic [7:0]  sdata,
    input  wire logic        frame_clock,
    input  wire logic        wide,
    output logic      [13:0] word_ff,
    output logic             valid_ff,
    output logic             skew_ff
);
    logic [3:0]  len;
    logic [3:0]  cnt_ff;
    logic [13:0] sh_ff;
    logic        frame_clock_d_ff;
    assign len = wide ? 4'he : 4'hc;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            frame_clock_d_ff <= 1'b1;
            cnt_ff    <= 4'h0;
            sh_ff     <= 14'h0;
            word_ff   <= 14'h0;
            valid_ff  <= 1'b0;
        end else begin
            frame_clock_d_ff <= frame_clock;
            valid_ff  <= 1'b0;
            if (frame_clock && !frame_clock_d_ff) begin
                word_ff  <= sh_ff;
                valid_ff <= (cnt_ff == len);
                sh_ff    <= {13'h0, sdata[0]};
                cnt_ff   <= 4'h1;
            end else if (cnt_ff != 4'h0 && cnt_ff < len) begin
                sh_ff  <= sh_ff | (14'(sdata[0]) << cnt_ff);
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            skew_ff <= 1'b0;
        end else begin
            skew_ff <= skew_ff | (sdata != {8{sdata[0]}});
        end
    end
endmodule // atsc_rx_model

// ==== tb/tb_top.sv ====
// Bench for trim, performance, wake-up and serial output
`timescale 1ns/100ps
module tb_top;
    logic                 mclk, resetn, cs_n, sclk, sdi, sdo, pd, slp, fc, wide, vld, skew;
    logic                 rdy, bch, bc0;
    logic [191:0]         sd;
    logic [7:0]           fb, ser;
    logic [13:0]          w;
    logic [1:0]           cmb;
    logic [5:0]           fst;
    logic signed [6:0]    tof, prev;
    logic [15:0]          q;
    atsc_pkg::atsc_perf_t pl;
    int                   fail_count, checks_done, n;
    int                   wk[4] = '{992, 640, 420, 260};
    logic [5:0]           tc[7] = '{6'h00, 6'h01, 6'h1f, 6'h20, 6'h21, 6'h3e, 6'h3f};
    logic [23:0]          dg[4] = '{24'h0, 24'haaaaaa, 24'hffffff, 24'h1};
    logic [7:0]           fv[4] = '{8'h00, 8'hff, 8'h00, 8'hff};
    logic [12:0]          sx[4] = '{13'h0, 13'h1fff, 13'h1ffe, 13'h801};
    atsc_top atsc_top_inst (.mclk(mclk), .resetn(resetn), .ctl_cs_n(cs_n), .ctl_sclk(sclk),
        .ctl_sdata(sdi), .ctl_sdout_ff(sdo), .pd_req(pd), .sleep_req(slp), .stage_digits(sd),
        .final_bits(fb), .serial_data_ff(ser), .frame_clock_ff(fc), .bit_clock_half_ff(bch),
        .wake_ready_ff(rdy), .perf_level_ff(pl), .common_mode_buffer_strength_ff(cmb),
        .full_scale_trim_ff(fst), .trim_offset_ff(tof));
    atsc_rx_model atsc_rx_model_inst (.mclk(mclk), .resetn(resetn), .sdata(ser), .frame_clock(fc),
        .wide(wide), .word_ff(w), .valid_ff(vld), .skew_ff(skew));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic ctl(input logic [7:0] a, input logic [15:0] d, output logic [15:0] rd);
        rd = 16'h0;
        cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sclk = 1'b0;
            sdi = (i > 15) ? a[i-16] : d[i];
            if (i < 16) rd[i] = sdo;
            repeat (2) @(negedge mclk);
            sclk = 1'b1;
            repeat (2) @(negedge mclk);
        end
        cs_n = 1'b1;
        sclk = 1'b0;
        repeat (3) @(negedge mclk);
    endtask
    task automatic wait_wake(output int cnt);
        cnt = 0;
        while (rdy !== 1'b1) begin
            @(negedge mclk);
            cnt++;
            if (cnt > 2000) begin
                fail_count++;
                print_verdict();
            end
        end
    endtask
    task automatic pulse(input logic s);
        pd = !s;
        slp = s;
        repeat (2) @(negedge mclk);
        pd = 1'b0;
        slp = 1'b0;
    endtask
    task automatic get_word();
        for (int k = 0; k < 3; k++) begin
            n = 0;
            @(negedge mclk);
            while (vld !== 1'b1) begin
                @(negedge mclk);
                n++;
                if (n > 100) begin
                    fail_count++;
                    print_verdict();
                end
            end
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        {fail_count, checks_done} = '0;
        {resetn, pd, slp, sclk, sdi, wide, sd, fb} = '0;
        cs_n = 1'b1;
        prev = 7'sh40;
        repeat (4) @(negedge mclk);
        resetn = 1'b1;
        wait_wake(n);
        chk(16'(n >= 992 && n <= 994), 16'h1);
        chk({13'h0, pl}, 16'h0);
        chk({14'h0, cmb}, 16'h1);
        chk({10'h0, fst}, 16'h20);
        ctl(8'h57, 16'h0, q);
        chk(q, 16'h1);
        ctl(8'h60, 16'hffff, q);
        ctl(8'h60, 16'h0, q);
        chk(q, 16'h0);
        ctl(8'h50, 16'h10, q);
        chk(q, 16'h10);
        foreach (tc[i]) begin
            ctl(8'h55, {10'h0, tc[i]}, q);
            chk({10'h0, fst}, {10'h0, tc[i]});
            chk({9'h0, tof}, {9'h0, 7'({1'b0, tc[i]} - 7'h20)});
            chk(16'(tof > prev), 16'h1);
            prev = tof;
        end
        for (int c = 0; c < 8; c++) begin
            ctl(8'h50, {10'h0, 2'(c), 1'b0, 3'(c)}, q);
            chk({13'h0, pl}, (c >= 1 && c <= 3) ? 16'h0 : 16'(c));
            chk({14'h0, cmb}, 16'(c % 4));
        end
        ctl(8'h50, 16'h10, q);
        chk(q, 16'h37);
        for (int r = 0; r < 4; r++) begin
            ctl(8'h56, 16'(r), q);
            pulse(r % 2 == 1);
            wait_wake(n);
            chk(16'(n >= wk[r] && n <= wk[r] + 2), 16'h1);
        end
        pulse(1'b0);
        fork
            wait_wake(n);
            ctl(8'h56, 16'h0, q);
        join
        chk(16'(n >= 260 && n <= 262), 16'h1);
        ctl(8'h56, 16'h3, q);
        chk(q, 16'h0);
        for (int m = 0; m < 2; m++) begin
            ctl(8'h53, 16'(m * 2), q);
            wide = (m == 1);
            foreach (dg[i]) begin
                sd = {8{dg[i]}};
                fb = fv[i];
                get_word();
                chk({2'h0, w}, m ? {2'h0, sx[i], 1'b0} : {4'h0, sx[i][12:1]});
            end
        end
        fb = 8'h00;
        @(negedge mclk);
        fb = 8'hff;
        repeat (2) @(negedge mclk);
        bc0 = bch;
        @(negedge mclk);
        chk(16'(bch), 16'(!bc0));
        chk(16'(skew), 16'h0);
        print_verdict();
    end
endmodule // tb_top
